// [gpio_wake_pkg.sv]
/*
 Constants for the four-port GPIO block with port A wake-up: register map,
 implemented-bit masks, reset values and power states.
 Assumes a byte-wide register port with a 5-bit address.
*/
`default_nettype none
package gpio_wake_pkg;
	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int NUM_PORTS = 4;
	localparam int PORT_W    = 8;
	localparam int ADDR_W    = 5;

	// ------------------------------------------------------------------
	// Register map: addr[4]=0 is port space, addr[3:2] port, addr[1:0] sel
	// ------------------------------------------------------------------
	localparam logic [1:0] SEL_DATA   = 2'h0;
	localparam logic [1:0] SEL_DIR    = 2'h1;
	localparam logic [1:0] SEL_PULLUP = 2'h2;
	localparam logic [1:0] SEL_WAKE   = 2'h3;
	localparam int         PORT_SPACE_BIT = 4;
	localparam logic [ADDR_W-1:0] OFS_WAKE_STATUS = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_WAKE_MASK   = 5'h11;
	localparam logic [ADDR_W-1:0] OFS_SLEEP_CTRL  = 5'h12;
	localparam int         SLEEP_BIT = 0;

	// ------------------------------------------------------------------
	// Implemented bits per port (A, B, C, D)
	// ------------------------------------------------------------------
	localparam logic [PORT_W-1:0] IMPL_MASK [NUM_PORTS] = '{8'hff, 8'hff, 8'hff, 8'h03};
	localparam logic [PORT_W-1:0] PU_MASK   [NUM_PORTS] = '{8'h7f, 8'hff, 8'hff, 8'h03};

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [PORT_W-1:0] DATA_RST   = 8'hff;
	localparam logic [PORT_W-1:0] DIR_RST    = 8'hff;
	localparam logic [PORT_W-1:0] PULLUP_RST = 8'h00;
	localparam logic [PORT_W-1:0] WAKE_RST   = 8'h00;
	localparam logic [PORT_W-1:0] STATUS_RST = 8'h00;
	localparam logic [PORT_W-1:0] MASK_RST   = 8'h00;
	localparam logic [PORT_W-1:0] SYNC_RST   = 8'hff;

	// ------------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------------
	typedef enum logic {PWR_RUN, PWR_SLEEP} power_state_t;
endpackage
`default_nettype wire

// [gpio_ports_with_wake.sv]
/*
 Four bidirectional GPIO ports with direction, pull-up enable, output
 latches and port A falling-edge wake-up from sleep, plus a sticky wake
 status with mask and one interrupt line.
 Assumes i_ref_clk is the always-on clock; o_clk_stop gates the core clock
 elsewhere, and pad logic resolves pin level from o_oe_* and o_pin_*.
*/
// Notes on behaviour
// - Port input reads are not latched, the live synchronised pin level is taken with the read.
// - Written output data stays in its latch and drives unchanged until written again.
// - An input bit gets its weak pull-up when its pull-up enable is 1, none when 0.
// - Port A bit 7 has no pull-up and its enable bit does not exist.
// - A sleep command stops the core clock and holds it stopped until a wake-up.
// - While asleep, a falling edge on any wake-enabled port A pin wakes the core.
// - Each port A pin has its own wake enable, 1 enables, and all reset to zero.
// - A direction bit of 0 makes the pin an output, 1 makes it an input.
// - Unimplemented bits of direction, pull-up and wake enable registers read as zero.
// - Reset sets output latches high so a pin later made an output drives high.
// - Reading an output bit returns the output latch, not the pin level.
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_with_wake (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [4:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic [7:0]  i_pin_a,
	input  wire logic [7:0]  i_pin_b,
	input  wire logic [7:0]  i_pin_c,
	input  wire logic [7:0]  i_pin_d,
	output logic      [7:0]  o_pin_a,
	output logic      [7:0]  o_pin_b,
	output logic      [7:0]  o_pin_c,
	output logic      [7:0]  o_pin_d,
	output logic      [7:0]  o_oe_a,
	output logic      [7:0]  o_oe_b,
	output logic      [7:0]  o_oe_c,
	output logic      [7:0]  o_oe_d,
	output logic      [7:0]  o_pullup_a,
	output logic      [7:0]  o_pullup_b,
	output logic      [7:0]  o_pullup_c,
	output logic      [7:0]  o_pullup_d,
	output logic             o_irq,
	output logic             o_clk_stop,
	output logic             o_wake
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [7:0]  data_q   [gpio_wake_pkg::NUM_PORTS];
	logic [7:0]  dir_q    [gpio_wake_pkg::NUM_PORTS];
	logic [7:0]  pu_q     [gpio_wake_pkg::NUM_PORTS];
	logic [7:0]  pull_q   [gpio_wake_pkg::NUM_PORTS];
	logic [7:0]  oe_q     [gpio_wake_pkg::NUM_PORTS];
	logic [7:0]  sync1_q  [gpio_wake_pkg::NUM_PORTS];
	logic [7:0]  sync2_q  [gpio_wake_pkg::NUM_PORTS];
	logic [7:0]  rd_val   [gpio_wake_pkg::NUM_PORTS];
	wire  [7:0]  pin_in   [gpio_wake_pkg::NUM_PORTS];
	logic [7:0]  prev_a_q;
	logic [7:0]  wake_en_q;
	logic [7:0]  status_q;
	logic [7:0]  status_d;
	logic [7:0]  mask_q;
	logic [7:0]  rdata_q;
	logic        irq_q;
	logic        clk_stop_q;
	logic        wake_q;
	gpio_wake_pkg::power_state_t state_q;
	gpio_wake_pkg::power_state_t state_d;

	wire         port_space = ~i_addr[gpio_wake_pkg::PORT_SPACE_BIT];
	wire  [1:0]  port_idx   = i_addr[3:2];
	wire  [1:0]  reg_sel    = i_addr[1:0];
	wire  [7:0]  fall_a;
	wire  [7:0]  clr_bits;
	wire         wr_sleep;
	wire         any_wake;
	wire  [7:0]  rdata_d;
	wire  [7:0]  misc_rd;

	// Input for a pin: live level if input, latch if output
	function automatic logic [7:0] port_read(input logic [7:0] dat,
		input logic [7:0] dir, input logic [7:0] pin);
		port_read = (dir & pin) | (~dir & dat);
	endfunction

	assign pin_in[0] = i_pin_a;
	assign pin_in[1] = i_pin_b;
	assign pin_in[2] = i_pin_c;
	assign pin_in[3] = i_pin_d;

	// ------------------------------------------------------------------
	// Per-port logic
	// ------------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < gpio_wake_pkg::NUM_PORTS; p++) begin : g_port
			wire hit = i_wr & port_space & (port_idx == 2'(p));
			wire [7:0] impl = gpio_wake_pkg::IMPL_MASK[p];
			wire [7:0] pmsk = gpio_wake_pkg::PU_MASK[p];

			// Two-flop synchroniser; only sync2 is read by logic
			always_ff @(posedge i_ref_clk) begin
				if (i_sys_rst) begin
					sync1_q[p] <= gpio_wake_pkg::SYNC_RST;
					sync2_q[p] <= gpio_wake_pkg::SYNC_RST;
				end else begin
					sync1_q[p] <= pin_in[p];
					sync2_q[p] <= sync1_q[p];
				end
			end

			// Output latch, direction and pull-up enable registers
			always_ff @(posedge i_ref_clk) begin
				if (i_sys_rst) begin
					data_q[p] <= gpio_wake_pkg::DATA_RST & impl;
					dir_q[p]  <= gpio_wake_pkg::DIR_RST & impl;
					pu_q[p]   <= gpio_wake_pkg::PULLUP_RST;
				end else if (hit) begin
					if (reg_sel == gpio_wake_pkg::SEL_DATA)
						data_q[p] <= i_wdata & impl;
					if (reg_sel == gpio_wake_pkg::SEL_DIR)
						dir_q[p] <= i_wdata & impl;
					if (reg_sel == gpio_wake_pkg::SEL_PULLUP)
						pu_q[p] <= i_wdata & pmsk;
				end
			end

			// Pad controls are flopped so outputs come from registers;
			// the one-cycle lag is harmless for weak pull-ups
			always_ff @(posedge i_ref_clk) begin
				if (i_sys_rst) begin
					pull_q[p] <= gpio_wake_pkg::PULLUP_RST;
					oe_q[p]   <= ~gpio_wake_pkg::DIR_RST;
				end else begin
					pull_q[p] <= pu_q[p] & dir_q[p] & pmsk;
					oe_q[p]   <= ~dir_q[p] & impl;
				end
			end

			// Read value of the selected register of this port
			assign rd_val[p] =
				(reg_sel == gpio_wake_pkg::SEL_DATA)   ?
					port_read(data_q[p], dir_q[p], sync2_q[p]) & impl :
				(reg_sel == gpio_wake_pkg::SEL_DIR)    ? dir_q[p] :
				(reg_sel == gpio_wake_pkg::SEL_PULLUP) ? pu_q[p] :
				(p == 0) ? wake_en_q : 8'h00;
		end
	endgenerate

	// ------------------------------------------------------------------
	// Port A wake detection and sticky status
	// ------------------------------------------------------------------
	// Edge seen on the always-on clock, so the stopped core clock is no hazard
	assign fall_a   = prev_a_q & ~sync2_q[0] & wake_en_q;
	assign any_wake = |fall_a;
	assign clr_bits = (i_wr && i_addr == gpio_wake_pkg::OFS_WAKE_STATUS) ? i_wdata : 8'h00;
	// Set wins over a write-one-to-clear in the same cycle
	assign status_d = (status_q & ~clr_bits) | fall_a;
	assign wr_sleep = i_wr && (i_addr == gpio_wake_pkg::OFS_SLEEP_CTRL)
		&& i_wdata[gpio_wake_pkg::SLEEP_BIT];

	// Previous synchronised level, wake enable, status and mask
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			prev_a_q  <= gpio_wake_pkg::SYNC_RST;
			wake_en_q <= gpio_wake_pkg::WAKE_RST;
			status_q  <= gpio_wake_pkg::STATUS_RST;
			mask_q    <= gpio_wake_pkg::MASK_RST;
		end else begin
			prev_a_q <= sync2_q[0];
			status_q <= status_d;
			if (i_wr && port_space && port_idx == 2'h0 && reg_sel == gpio_wake_pkg::SEL_WAKE)
				wake_en_q <= i_wdata;
			if (i_wr && i_addr == gpio_wake_pkg::OFS_WAKE_MASK)
				mask_q <= i_wdata;
		end
	end

	// ------------------------------------------------------------------
	// Sleep state
	// ------------------------------------------------------------------
	// Sleep entered by command; a wake edge in the same cycle keeps running
	always_comb begin
		state_d = state_q;
		case (state_q)
			gpio_wake_pkg::PWR_RUN: begin
				if (wr_sleep && !any_wake)
					state_d = gpio_wake_pkg::PWR_SLEEP;
			end
			gpio_wake_pkg::PWR_SLEEP: begin
				if (any_wake)
					state_d = gpio_wake_pkg::PWR_RUN;
			end
			default: state_d = gpio_wake_pkg::PWR_RUN;
		endcase
	end

	// State, clock stop, wake pulse and interrupt flops
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_q    <= gpio_wake_pkg::PWR_RUN;
			clk_stop_q <= 1'b0;
			wake_q     <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			clk_stop_q <= (state_d == gpio_wake_pkg::PWR_SLEEP);
			wake_q     <= (state_q == gpio_wake_pkg::PWR_SLEEP) && any_wake;
			irq_q      <= |(status_d & mask_q);
		end
	end

	// ------------------------------------------------------------------
	// Register read path
	// ------------------------------------------------------------------
	// Unmapped addresses read zero
	assign misc_rd =
		(i_addr == gpio_wake_pkg::OFS_WAKE_STATUS) ? status_q :
		(i_addr == gpio_wake_pkg::OFS_WAKE_MASK)   ? mask_q :
		(i_addr == gpio_wake_pkg::OFS_SLEEP_CTRL)  ?
			{7'h00, state_q == gpio_wake_pkg::PWR_SLEEP} : 8'h00;
	assign rdata_d = port_space ? rd_val[port_idx] : misc_rd;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst)
			rdata_q <= 8'h00;
		else
			rdata_q <= i_rd ? rdata_d : 8'h00;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_rdata    = rdata_q;
	assign o_pin_a    = data_q[0];
	assign o_pin_b    = data_q[1];
	assign o_pin_c    = data_q[2];
	assign o_pin_d    = data_q[3];
	assign o_oe_a     = oe_q[0];
	assign o_oe_b     = oe_q[1];
	assign o_oe_c     = oe_q[2];
	assign o_oe_d     = oe_q[3];
	assign o_pullup_a = pull_q[0];
	assign o_pullup_b = pull_q[1];
	assign o_pullup_c = pull_q[2];
	assign o_pullup_d = pull_q[3];
	assign o_irq      = irq_q;
	assign o_clk_stop = clk_stop_q;
	assign o_wake     = wake_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	wire rd_a_data = i_rd && i_addr == 5'h00;

	// Checked bit by bit so reads of a mixed-direction port are covered as well
	property p_input_live;
		rd_a_data |=> (o_rdata & $past(dir_q[0])) == ($past(sync2_q[0]) & $past(dir_q[0]));
	endproperty
	a_input_live: assert property (p_input_live) else $error("input read not live");

	property p_latch_hold;
		!(i_wr && i_addr == 5'h00) |=> $stable(o_pin_a);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

	property p_pullup_gate;
		!$past(i_sys_rst) |-> o_pullup_b == $past(pu_q[1] & dir_q[1]);
	endproperty
	a_pullup_gate: assert property (p_pullup_gate) else $error("pull-up wrong");

	property p_pa7_nopull;
		!o_pullup_a[7] && !pu_q[0][7];
	endproperty
	a_pa7_nopull: assert property (p_pa7_nopull) else $error("bit 7 pull-up");

	property p_sleep_enter;
		wr_sleep && !any_wake && !clk_stop_q |=> o_clk_stop [*2] or (o_clk_stop ##1 o_wake);
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("no sleep");

	property p_wake;
		o_clk_stop && any_wake |=> !o_clk_stop && o_wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	property p_wake_reset;
		$past(i_sys_rst) |-> wake_en_q == 8'h00 && !o_clk_stop;
	endproperty
	a_wake_reset: assert property (p_wake_reset) else $error("wake enable reset");

	property p_dir_oe;
		!$past(i_sys_rst) |-> o_oe_c == ~$past(dir_q[2]);
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("oe mismatch");

	property p_unimpl_zero;
		i_rd && i_addr inside {5'h0d, 5'h0e} |=> o_rdata[7:2] == 6'h00;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimpl nonzero");

	property p_reset_vals;
		$past(i_sys_rst) |-> dir_q[0] == 8'hff && pu_q[0] == 8'h00 && data_q[1] == 8'hff;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values");

	property p_out_read;
		rd_a_data |=> (o_rdata & ~$past(dir_q[0])) == ($past(data_q[0]) & ~$past(dir_q[0]));
	endproperty
	a_out_read: assert property (p_out_read) else $error("output read");

	property p_set_wins;
		|fall_a |=> (status_q & $past(fall_a)) == $past(fall_a);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("status lost");

	// Read data must not linger once the strobe has gone
	property p_rdata_idle;
		!i_rd |=> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

	// Interrupt follows the settled status against the mask of the cycle before
	property p_irq_level;
		!$past(i_sys_rst) |-> o_irq == |(status_q & $past(mask_q));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

	c_sleep_wake: cover property (wr_sleep ##[1:50] o_wake);
	c_input_read: cover property (rd_a_data && |dir_q[0] && |(~dir_q[0]));
	c_irq:        cover property (!o_irq ##1 o_irq);
	c_set_clear:  cover property (|(fall_a & clr_bits));
endmodule // gpio_ports_with_wake
`default_nettype wire

// [gpio_board_model.sv]
/*
 Board model for the four GPIO ports: resolves each pin from the device
 drive, an external source and the weak pull-up.
 Assumes the four ports are packed {d, c, b, a}, eight bits each.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_board_model (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_out,
	input  wire logic [31:0] i_oe,
	input  wire logic [31:0] i_pu,
	input  wire logic [31:0] i_ext_val,
	input  wire logic [31:0] i_ext_en,
	output logic      [31:0] o_level
);
	// ------------------------------------------------------------------
	// Floating pins
	// ------------------------------------------------------------------
	// An undriven pin toggles every cycle so a stale value never passes for a good one
	logic [31:0] float_q = 32'h5555_5555;
	always_ff @(posedge i_clk) begin
		float_q <= ~float_q;
	end

	// Device drive wins, then the switch, then the pull-up, else noise
	assign o_level = (i_oe & i_out)
		| (~i_oe & i_ext_en & i_ext_val)
		| (~i_oe & ~i_ext_en & i_pu)
		| (~i_oe & ~i_ext_en & ~i_pu & float_q);
endmodule // gpio_board_model
`default_nettype wire

// [gpio_ports_with_wake_tb.sv]
/*
 Self-checking bench for the GPIO ports with port A wake-up.
 Assumes the board model sits on the pins and the register port answers
 reads one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_with_wake_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  addr = 5'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic        rd_seen = 1'b0;
	logic [31:0] ext_val = 32'hffff_ffff;
	logic [31:0] ext_en = 32'h0000_0000;
	logic [7:0]  exp_q [$];
	logic [7:0]  m, d, r, v;
	int          n_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          p, k;
	wire logic [7:0]  o_rdata;
	wire logic [31:0] lvl, pin_o, oe_o, pu_o;
	wire logic        o_irq, o_clk_stop, o_wake;
	wire logic [7:0]  pa, pb, pc, pd, ea, eb, ec, ed, ua, ub, uc, ud;

	assign pin_o = {pd, pc, pb, pa};
	assign oe_o = {ed, ec, eb, ea};
	assign pu_o = {ud, uc, ub, ua};
	always #2 clk = ~clk;

	gpio_ports_with_wake dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .o_rdata(o_rdata), .i_pin_a(lvl[7:0]), .i_pin_b(lvl[15:8]),
		.i_pin_c(lvl[23:16]), .i_pin_d(lvl[31:24]), .o_pin_a(pa), .o_pin_b(pb), .o_pin_c(pc),
		.o_pin_d(pd), .o_oe_a(ea), .o_oe_b(eb), .o_oe_c(ec), .o_oe_d(ed), .o_pullup_a(ua),
		.o_pullup_b(ub), .o_pullup_c(uc), .o_pullup_d(ud), .o_irq(o_irq),
		.o_clk_stop(o_clk_stop), .o_wake(o_wake));
	gpio_board_model board (.i_clk(clk), .i_out(pin_o), .i_oe(oe_o), .i_pu(pu_o),
		.i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(lvl));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// An idle edge after each strobe keeps one assignment per signal per step
	task automatic wr(input logic [4:0] a, input logic [7:0] dt);
		addr <= a;
		wdata <= dt;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		exp_q.push_back(exp);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
	endtask

	// ------------------------------------------------------------------
	// Read data monitor: data stand only in the cycle after the strobe
	// ------------------------------------------------------------------
	always @(posedge clk) rd_seen <= rd_s;
	always @(negedge clk) begin
		if (rd_seen)
			check("rdata", o_rdata, exp_q.pop_front());
		else
			check("rdata_idle", o_rdata, 8'h00);
	end

	// Hang guard, far above the roughly 150 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			close_out();
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(10963));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset state of every port
		for (p = 0; p < 4; p++) begin
			m = gpio_wake_pkg::IMPL_MASK[p];
			rd(5'(p * 4 + 1), gpio_wake_pkg::DIR_RST & m);
			rd(5'(p * 4 + 2), 8'h00);
			@(negedge clk);
			check("pin_rst", pin_o[p*8+:8], gpio_wake_pkg::DATA_RST & m);
			check("oe_rst", oe_o[p*8+:8], 8'h00);
			check("pu_rst", pu_o[p*8+:8], 8'h00);
			@(posedge clk);
		end
		rd(5'h03, 8'h00);
		wr(5'h07, 8'hff);
		rd(5'h07, 8'h00);
		rd(5'h13, 8'h00);
		// Wake: only enabled port A pins end the sleep
		ext_en[7:0] <= 8'hff;
		wr(5'h03, 8'h01);
		wr(gpio_wake_pkg::OFS_WAKE_MASK, 8'h01);
		repeat (3) @(posedge clk);
		wr(gpio_wake_pkg::OFS_SLEEP_CTRL, 8'h01);
		rd(gpio_wake_pkg::OFS_SLEEP_CTRL, 8'h01);
		ext_val[7:0] <= 8'hfb;
		repeat (6) @(posedge clk);
		@(negedge clk);
		check("stop_held", {7'h0, o_clk_stop}, 8'h01);
		check("irq_none", {7'h0, o_irq}, 8'h00);
		@(posedge clk);
		rd(gpio_wake_pkg::OFS_WAKE_STATUS, 8'h00);
		ext_val[7:0] <= 8'hfa;
		k = 0;
		@(negedge clk);
		while (o_wake !== 1'b1 && k < 10) begin
			k++;
			@(negedge clk);
		end
		check("wake", {7'h0, o_wake}, 8'h01);
		check("stop_off", {7'h0, o_clk_stop}, 8'h00);
		check("irq_set", {7'h0, o_irq}, 8'h01);
		@(posedge clk);
		rd(gpio_wake_pkg::OFS_WAKE_STATUS, 8'h01);
		wr(gpio_wake_pkg::OFS_WAKE_MASK, 8'h00);
		@(negedge clk);
		check("irq_masked", {7'h0, o_irq}, 8'h00);
		@(posedge clk);
		wr(gpio_wake_pkg::OFS_WAKE_MASK, 8'h01);
		@(negedge clk);
		check("irq_unmasked", {7'h0, o_irq}, 8'h01);
		@(posedge clk);
		wr(gpio_wake_pkg::OFS_WAKE_STATUS, 8'h01);
		@(negedge clk);
		check("irq_clear", {7'h0, o_irq}, 8'h00);
		@(posedge clk);
		// Random direction, data and pin mix on every port, with every pull-up enable written to 1
		for (p = 0; p < 4; p++) begin
			m = gpio_wake_pkg::IMPL_MASK[p];
			d = 8'($urandom);
			r = 8'($urandom);
			v = 8'($urandom);
			wr(5'(p * 4 + 2), 8'hff);
			rd(5'(p * 4 + 2), gpio_wake_pkg::PU_MASK[p]);
			wr(5'(p * 4 + 1), d);
			wr(5'(p * 4), r);
			ext_val[p*8+:8] <= v;
			ext_en[p*8+:8] <= 8'hff;
			repeat (3) @(posedge clk);
			rd(5'(p * 4 + 1), d & m);
			rd(5'(p * 4), ((v & d) | (r & ~d)) & m);
			@(negedge clk);
			check("oe", oe_o[p*8+:8], ~d & m);
			check("pin", pin_o[p*8+:8], r & m);
			check("pu", pu_o[p*8+:8], gpio_wake_pkg::PU_MASK[p] & d);
			@(posedge clk);
		end
		repeat (2) @(posedge clk);
		close_out();
	end
endmodule // gpio_ports_with_wake_tb
`default_nettype wire
